// ### logic/hs_dac_pkg.sv
// register map, field layout and reset values of the fast dac control block
// assumes a 16-bit byte address taken from the low bits of the apb address
package hs_dac_pkg;

  // ****************************************************************
  // ***                     register offsets                     ***
  // ****************************************************************
  localparam logic [15:0] OFS_CONFIG       = 16'h2010;
  localparam logic [15:0] OFS_CODE         = 16'h2048;
  localparam logic [15:0] OFS_LOCK         = 16'h2230;
  localparam logic [15:0] OFS_GAIN_TRIM    = 16'h2260;
  localparam logic [15:0] OFS_OFF_LP_ATTEN = 16'h2264;
  localparam logic [15:0] OFS_OFF_LP       = 16'h2268;
  localparam logic [15:0] OFS_OFF_HP_ATTEN = 16'h22b8;
  localparam logic [15:0] OFS_OFF_HP       = 16'h22bc;
  localparam logic [15:0] OFS_POWER_BW     = 16'h22f0;
  localparam logic [15:0] OFS_AUX_CTRL     = 16'h22f4;
  localparam logic [15:0] OFS_STATUS       = 16'h22f8;

  // ****************************************************************
  // ***                      field layout                        ***
  // ****************************************************************
  localparam int CFG_AMP_BIT   = 0;
  localparam int CFG_RATE_LSB  = 1;
  localparam int CFG_RATE_MSB  = 8;
  localparam int CFG_ATTEN_BIT = 12;
  localparam logic [31:0] CFG_WR_MASK = 32'h0000_11ff;
  localparam int PWR_MODE_BIT  = 0;
  localparam int PWR_FILT_LSB  = 2;
  localparam int PWR_FILT_MSB  = 3;
  localparam logic [31:0] PWR_WR_MASK = 32'h0000_000d;
  localparam int AUX_CLK_BIT   = 0;
  localparam int AUX_DCBUF_BIT = 1;
  localparam int CODE_W        = 12;
  localparam int TRIM_W        = 12;
  localparam int TRIM_NUM      = 5;

  // ****************************************************************
  // ***                      reset values                        ***
  // ****************************************************************
  localparam logic [31:0] CONFIG_RST = 32'h0000_001e;
  localparam logic [11:0] CODE_RST   = 12'h800;
  localparam logic [31:0] LOCK_RST   = 32'hde87_a5a0;
  localparam logic [11:0] GAIN_RST   = 12'h800;
  localparam logic [11:0] OFFSET_RST = 12'h000;
  localparam logic [31:0] POWER_RST  = 32'h0000_0000;
  localparam logic [1:0]  AUX_RST    = 2'h0;
  // value that opens the trim registers; arbitrary
  localparam logic [31:0] LOCK_KEY   = 32'h0000_c0de;

  // true when a word address selects a register offset
  function automatic logic reg_hit(input logic [15:0] addr,
                                   input logic [15:0] ofs);
    reg_hit = (addr[15:2] == ofs[15:2]);
  endfunction : reg_hit

endpackage : hs_dac_pkg

// ### logic/cal_if.sv
// carries the trim bank access and its results between control and bank
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface cal_if;
  import hs_dac_pkg::*;
  logic [15:0]       addr;
  logic [31:0]       wdata;
  logic              wr;
  logic [31:0]       rdata;
  logic              hit;
  logic              refused;
  logic              unlocked;
  logic [TRIM_W-1:0] trim [TRIM_NUM];

  modport ctrl (output addr, wdata, wr,
                input  rdata, hit, refused, unlocked, trim);
  modport bank (input  addr, wdata, wr,
                output rdata, hit, refused, unlocked, trim);
endinterface : cal_if

// ### logic/cal_trim_bank.sv
// lock register and gain and offset trim registers of the fast dac
// assumes wr is a one-cycle pulse at the completing bus edge
`timescale 1ns/10ps
module cal_trim_bank (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // access from the control block
  cal_if.bank      cal
);
  import hs_dac_pkg::*;

  // ****************************************************************
  // ***                        storage                           ***
  // ****************************************************************
  localparam logic [15:0] TRIM_OFS [TRIM_NUM] = '{OFS_GAIN_TRIM,
    OFS_OFF_LP_ATTEN, OFS_OFF_LP, OFS_OFF_HP_ATTEN, OFS_OFF_HP};
  localparam logic [11:0] TRIM_RST [TRIM_NUM] = '{GAIN_RST,
    OFFSET_RST, OFFSET_RST, OFFSET_RST, OFFSET_RST};

  logic [31:0]        lock_q;
  logic [TRIM_W-1:0]  trim_q [TRIM_NUM];
  logic [TRIM_NUM-1:0] trim_sel;
  logic               lock_sel;

  assign lock_sel     = reg_hit(cal.addr, OFS_LOCK);
  assign cal.unlocked = (lock_q == LOCK_KEY);
  assign cal.hit      = lock_sel | (|trim_sel);
  assign cal.refused  = (|trim_sel) & ~cal.unlocked;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lock_q <= LOCK_RST;
    end else if (cal.wr && lock_sel) begin
      lock_q <= cal.wdata;
    end
  end

  genvar i;
  generate
    for (i = 0; i < TRIM_NUM; i++) begin : g_trim
      assign trim_sel[i] = reg_hit(cal.addr, TRIM_OFS[i]);
      assign cal.trim[i] = trim_q[i];
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          trim_q[i] <= TRIM_RST[i];
        end else if (cal.wr && trim_sel[i] && cal.unlocked) begin
          trim_q[i] <= cal.wdata[TRIM_W-1:0];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // ***                       read back                          ***
  // ****************************************************************
  always_comb begin
    cal.rdata = lock_sel ? lock_q : 32'h0000_0000;
    for (int k = 0; k < TRIM_NUM; k++) begin
      if (trim_sel[k]) begin
        cal.rdata = {{(32-TRIM_W){1'b0}}, trim_q[k]};
      end
    end
  end

endmodule : cal_trim_bank

// ### logic/hs_dac_mode_control.sv
// control of the fast excitation dac: power mode, filter, scaling, update
// rate divider, clock gating in hibernate and locked trim registers
// assumes an apb master on core_clk and hibernate synchronous to core_clk
`timescale 1ns/10ps

module hs_dac_mode_control (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // power state
  input  wire logic        hibernate,
  // analog controls
  output logic             high_power,
  output logic             clk_32m_sel,
  output logic [1:0]       filter_sel,
  output logic             atten_en,
  output logic             amp_gain_hi,
  output logic             dc_buf_en,
  output logic             dac_clk_en,
  output logic [11:0]      dac_code,
  output logic             dac_update,
  output logic [11:0]      dac_gain_trim,
  output logic [11:0]      dac_offset_trim
);
  import hs_dac_pkg::*;

  // ****************************************************************
  // ***                    bus handshake                         ***
  // ****************************************************************
  cal_if cal ();

  logic        pready_q, pready_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pslverr_q, pslverr_d;
  logic        commit, wr_commit;
  logic        sel_cfg, sel_code, sel_pwr, sel_aux, sel_stat, hit_any;

  // one wait state: answer in the second access cycle
  assign pready_d  = psel & penable & ~pready_q;
  assign commit    = psel & penable & pready_q;
  assign wr_commit = commit & pwrite;

  assign sel_cfg  = reg_hit(paddr, OFS_CONFIG);
  assign sel_code = reg_hit(paddr, OFS_CODE);
  assign sel_pwr  = reg_hit(paddr, OFS_POWER_BW);
  assign sel_aux  = reg_hit(paddr, OFS_AUX_CTRL);
  assign sel_stat = reg_hit(paddr, OFS_STATUS);
  // unmapped addresses answer with an error and zero data
  assign hit_any  = sel_cfg | sel_code | sel_pwr | sel_aux | sel_stat
                  | cal.hit;

  assign cal.addr  = paddr;
  assign cal.wdata = pwdata;
  assign cal.wr    = wr_commit;

  cal_trim_bank u_bank (
    .core_clk (core_clk),
    .reset    (reset),
    .cal      (cal.bank)
  );

  // ****************************************************************
  // ***                   control registers                      ***
  // ****************************************************************
  logic [31:0]       cfg_q;
  logic [11:0]       code_q;
  logic [31:0]       pwr_q;
  logic [1:0]        aux_q;
  logic              clk_en_q;
  logic [7:0]        div_q, div_d;
  logic [7:0]        rate;
  logic              upd_q, upd_d;
  logic [11:0]       gain_q, offset_q, offset_d;
  logic [31:0]       stat_word;

  // writes land only at the completing edge; a refused access moves nothing
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_q <= CONFIG_RST;
    end else if (wr_commit && sel_cfg) begin
      cfg_q <= pwdata & CFG_WR_MASK;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      code_q <= CODE_RST;
    end else if (wr_commit && sel_code) begin
      code_q <= pwdata[CODE_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pwr_q <= POWER_RST;
    end else if (wr_commit && sel_pwr) begin
      pwr_q <= pwdata & PWR_WR_MASK;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      aux_q <= AUX_RST;
    end else if (wr_commit && sel_aux) begin
      aux_q <= pwdata[1:0];
    end
  end

  // ****************************************************************
  // ***              clock gating and update divider             ***
  // ****************************************************************
  assign rate  = cfg_q[CFG_RATE_MSB:CFG_RATE_LSB];
  // rate zero is treated as divide by one
  // the count restarts while gated, so the first update after wake-up
  // comes one full period after the clock returns
  assign upd_d = clk_en_q & ((rate == 8'h00) | (div_q >= rate - 8'h01));
  assign div_d = (!clk_en_q || upd_d) ? 8'h00 : div_q + 8'h01;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      clk_en_q <= 1'b0;
      div_q    <= 8'h00;
      upd_q    <= 1'b0;
    end else begin
      clk_en_q <= aux_q[AUX_CLK_BIT] & ~hibernate;
      div_q    <= div_d;
      upd_q    <= upd_d;
    end
  end

  // ****************************************************************
  // ***                   trim selection                         ***
  // ****************************************************************
  // offset trim follows power mode and attenuator setting
  // copies are registered so every analog input comes from a flip-flop
  assign offset_d = pwr_q[PWR_MODE_BIT]
    ? (cfg_q[CFG_ATTEN_BIT] ? cal.trim[3] : cal.trim[4])
    : (cfg_q[CFG_ATTEN_BIT] ? cal.trim[1] : cal.trim[2]);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      gain_q   <= GAIN_RST;
      offset_q <= OFFSET_RST;
    end else begin
      gain_q   <= cal.trim[0];
      offset_q <= offset_d;
    end
  end

  // ****************************************************************
  // ***                       read back                          ***
  // ****************************************************************
  assign stat_word = {29'h0000_0000, pwr_q[PWR_MODE_BIT], clk_en_q,
                      cal.unlocked};

  assign prdata_d = sel_cfg  ? cfg_q :
                    sel_code ? {20'h0_0000, code_q} :
                    sel_pwr  ? pwr_q :
                    sel_aux  ? {30'h0000_0000, aux_q} :
                    sel_stat ? stat_word :
                    cal.rdata;
  assign pslverr_d = pready_d & (~hit_any | (pwrite & cal.refused));
  // read data is zero outside the answering cycle

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= pready_d;
      prdata_q  <= (pready_d && !pwrite) ? prdata_d : 32'h0000_0000;
      pslverr_q <= pslverr_d;
    end
  end

  // ****************************************************************
  // ***                        outputs                           ***
  // ****************************************************************
  assign pready          = pready_q;
  assign prdata          = prdata_q;
  assign pslverr         = pslverr_q;
  // power mode and clock select outputs follow the mode bit: one means 32 MHz
  assign high_power      = pwr_q[PWR_MODE_BIT];
  assign clk_32m_sel     = pwr_q[PWR_MODE_BIT];
  assign filter_sel      = pwr_q[PWR_FILT_MSB:PWR_FILT_LSB];
  assign atten_en        = cfg_q[CFG_ATTEN_BIT];
  assign amp_gain_hi     = cfg_q[CFG_AMP_BIT];
  assign dc_buf_en       = aux_q[AUX_DCBUF_BIT];
  assign dac_clk_en      = clk_en_q;
  assign dac_code        = code_q;
  assign dac_update      = upd_q;
  assign dac_gain_trim   = gain_q;
  assign dac_offset_trim = offset_q;

endmodule : hs_dac_mode_control

// ### verif/hs_dac_chk.sv
// assertion checker for the fast dac control block
// assumes it is bound to hs_dac_mode_control and sees only its ports
`timescale 1ns/10ps
module hs_dac_chk
  import hs_dac_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // controls
  input wire logic        hibernate,
  input wire logic        high_power,
  input wire logic        clk_32m_sel,
  input wire logic [1:0]  filter_sel,
  input wire logic        atten_en,
  input wire logic        dac_update,
  input wire logic        dac_clk_en,
  input wire logic [11:0] dac_code,
  input wire logic [11:0] dac_gain_trim
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic wr_done, wr_pwr, wr_cfg, wr_code, wr_gain;
  assign wr_done = psel && penable && pready && pwrite;
  assign wr_pwr  = wr_done && (paddr[15:2] == OFS_POWER_BW[15:2]);
  assign wr_cfg  = wr_done && (paddr[15:2] == OFS_CONFIG[15:2]);
  assign wr_code = wr_done && (paddr[15:2] == OFS_CODE[15:2]);
  assign wr_gain = wr_done && (paddr[15:2] == OFS_GAIN_TRIM[15:2]);
  // ********
  // steps
  // ********
  sequence s_xfer; psel && !penable ##1 psel && penable; endsequence
  sequence s_hib; hibernate [*3]; endsequence
  property p_hi_clk; high_power |-> clk_32m_sel; endproperty
  a_hi_clk: assert property (p_hi_clk) else $error("no fast clock");
  property p_lo_clk; !high_power |-> !clk_32m_sel; endproperty
  a_lo_clk: assert property (p_lo_clk) else $error("no slow clock");
  property p_hib_clk; hibernate |=> !dac_clk_en; endproperty
  a_hib_clk: assert property (p_hib_clk) else $error("clock not gated");
  property p_hib_upd; s_hib |=> !dac_update; endproperty
  a_hib_upd: assert property (p_hib_upd) else $error("update in sleep");
  property p_wait; s_xfer |-> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("apb answer late");
  property p_mode; $changed(high_power) |-> $past(wr_pwr); endproperty
  a_mode: assert property (p_mode) else $error("mode moved alone");
  property p_filt; $changed(filter_sel) |-> $past(wr_pwr); endproperty
  a_filt: assert property (p_filt) else $error("filter moved alone");
  property p_att; $changed(atten_en) |-> $past(wr_cfg); endproperty
  a_att: assert property (p_att) else $error("atten moved alone");
  property p_code; $changed(dac_code) |-> $past(wr_code); endproperty
  a_code: assert property (p_code) else $error("code moved alone");
  property p_gain; $changed(dac_gain_trim) |-> $past(wr_gain, 2); endproperty
  a_gain: assert property (p_gain) else $error("gain moved alone");
  property p_pwr_wr;
    wr_pwr |=> (high_power == $past(pwdata[PWR_MODE_BIT]))
      && (filter_sel == $past(pwdata[PWR_FILT_MSB:PWR_FILT_LSB]));
  endproperty
  a_pwr_wr: assert property (p_pwr_wr) else $error("no mode write");
  property p_cfg_wr;
    wr_cfg |=> atten_en == $past(pwdata[CFG_ATTEN_BIT]);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("no atten write");
endmodule : hs_dac_chk

bind hs_dac_mode_control hs_dac_chk u_chk (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .hibernate(hibernate),
  .high_power(high_power), .clk_32m_sel(clk_32m_sel),
  .filter_sel(filter_sel), .atten_en(atten_en), .dac_update(dac_update),
  .dac_clk_en(dac_clk_en), .dac_code(dac_code),
  .dac_gain_trim(dac_gain_trim));

// ### verif/testbench.sv
// self-checking bench for the fast dac control block
// assumes an apb slave with a registered answer on core_clk
`timescale 1ns/10ps
module testbench;
  import hs_dac_pkg::*;
  logic        core_clk, reset, psel, penable, pwrite, hibernate;
  logic        pready, pslverr, high_power, clk_32m_sel, atten_en;
  logic        amp_gain_hi, dc_buf_en, dac_clk_en, dac_update;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  filter_sel;
  logic [11:0] dac_code, dac_gain_trim, dac_offset_trim;
  logic [7:0]  rates [2] = '{8'h07, 8'h1b};
  int          num_errors, checks_done, n;

  hs_dac_mode_control u_dut (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .hibernate(hibernate),
    .high_power(high_power), .clk_32m_sel(clk_32m_sel),
    .filter_sel(filter_sel), .atten_en(atten_en),
    .amp_gain_hi(amp_gain_hi), .dc_buf_en(dc_buf_en),
    .dac_clk_en(dac_clk_en), .dac_code(dac_code),
    .dac_update(dac_update), .dac_gain_trim(dac_gain_trim),
    .dac_offset_trim(dac_offset_trim));

  // concern clock source, oscillator, tia
  // front end and fourier settings of other blocks; core_clk stands for
  // whichever system clock software selects
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic final_report;
    if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; the request holds until pready is sampled high
  task automatic apb(input logic wr, input logic [15:0] a,
                     input logic [31:0] d, input logic [31:0] exp,
                     input logic e);
    int k;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (!wr) chk(prdata, exp);
    chk({31'h0, pslverr}, {31'h0, e});
    if (k >= 20) num_errors++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic count_upd(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge core_clk);
      if (dac_update === 1'b1) n++;
    end
  endtask : count_upd

  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, hibernate} = 4'h0;
    paddr = 16'h0;
    pwdata = 32'h0;
    num_errors = 0;
    checks_done = 0;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    apb(1'b0, OFS_CONFIG, 32'h0, 32'h0000_001e, 1'b0);
    apb(1'b0, OFS_CODE, 32'h0, 32'h0000_0800, 1'b0);
    apb(1'b0, OFS_LOCK, 32'h0, 32'hde87_a5a0, 1'b0);
    apb(1'b0, 16'h2000, 32'h0, 32'h0, 1'b1);
    chk({31'h0, clk_32m_sel}, 32'h0);
    for (int f = 1; f < 4; f++) begin
      apb(1'b1, OFS_POWER_BW, {28'h0, 2'(f), 2'b01}, 32'h0, 1'b0);
      @(posedge core_clk);
      chk({30'h0, filter_sel}, 32'(f));
      chk({30'h0, high_power, clk_32m_sel}, 32'h3);
    end
    apb(1'b1, OFS_POWER_BW, 32'hffff_fffe, 32'h0, 1'b0);
    apb(1'b0, OFS_POWER_BW, 32'h0, 32'h0000_000c, 1'b0);
    chk({30'h0, high_power, clk_32m_sel}, 32'h0);
    apb(1'b1, OFS_CONFIG, 32'h0000_1001, 32'h0, 1'b0);
    @(posedge core_clk);
    chk({30'h0, atten_en, amp_gain_hi}, 32'h3);
    apb(1'b1, OFS_CODE, 32'hffff_fe00, 32'h0, 1'b0);
    @(posedge core_clk);
    chk({20'h0, dac_code}, 32'h0000_0e00);
    apb(1'b0, OFS_CODE, 32'h0, 32'h0000_0e00, 1'b0);
    apb(1'b1, OFS_AUX_CTRL, 32'h0000_0003, 32'h0, 1'b0);
    foreach (rates[i]) begin
      apb(1'b1, OFS_POWER_BW, {31'h6, 1'(i == 0)}, 32'h0, 1'b0);
      apb(1'b1, OFS_CONFIG, {23'h0, rates[i], 1'b0}, 32'h0, 1'b0);
      repeat (40) @(posedge core_clk);
      count_upd(10 * rates[i]);
      chk(32'(n), 32'd10);
    end
    chk({30'h0, dc_buf_en, atten_en}, 32'h2);
    hibernate <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({31'h0, dac_clk_en}, 32'h0);
    count_upd(20);
    chk(32'(n), 32'd0);
    hibernate <= 1'b0;
    apb(1'b1, OFS_GAIN_TRIM, 32'h0000_0123, 32'h0, 1'b1);
    apb(1'b0, OFS_GAIN_TRIM, 32'h0, 32'h0000_0800, 1'b0);
    apb(1'b1, OFS_LOCK, LOCK_KEY, 32'h0, 1'b0);
    apb(1'b1, OFS_GAIN_TRIM, 32'h0000_0123, 32'h0, 1'b0);
    apb(1'b1, OFS_OFF_LP_ATTEN, 32'h0000_0456, 32'h0, 1'b0);
    apb(1'b1, OFS_CONFIG, 32'h0000_1000, 32'h0, 1'b0);
    repeat (3) @(posedge core_clk);
    chk({20'h0, dac_gain_trim}, 32'h0000_0123);
    chk({20'h0, dac_offset_trim}, 32'h0000_0456);
    apb(1'b0, OFS_STATUS, 32'h0, 32'h0000_0003, 1'b0);
    apb(1'b1, OFS_OFF_HP, 32'h0000_0789, 32'h0, 1'b0);
    apb(1'b1, OFS_POWER_BW, 32'h0000_0001, 32'h0, 1'b0);
    apb(1'b1, OFS_CONFIG, 32'h0000_0000, 32'h0, 1'b0);
    repeat (3) @(posedge core_clk);
    chk({20'h0, dac_offset_trim}, 32'h0000_0789);
    apb(1'b1, OFS_LOCK, 32'h0, 32'h0, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0, 32'h0000_0006, 1'b0);
    apb(1'b1, OFS_OFF_HP, 32'h0000_0001, 32'h0, 1'b1);
    apb(1'b0, OFS_OFF_HP, 32'h0, 32'h0000_0789, 1'b0);
    apb(1'b1, OFS_AUX_CTRL, 32'h0000_0002, 32'h0, 1'b0);
    repeat (2) @(posedge core_clk);
    chk({31'h0, dac_clk_en}, 32'h0);
    count_upd(20);
    chk(32'(n), 32'd0);
    final_report;
  end

  // the tests take well under a thousand cycles; this limit of 12500 cycles allows ample margin
  initial begin
    #100000;
    num_errors++;
    final_report;
  end
endmodule : testbench
